//--- hw/idec_core.sv
// Instruction decoder and sequencer of a small 8-bit core.
// Assumes program memory answers instr_word for prog_addr within one cycle, and
// the file registers answer file_rd_data combinationally to file_addr.
`timescale 1ns/1ps
`include "idec_params.svh"

module idec_core
  import idec_pkg::*;
(
  input logic ref_clk,
  input logic resetn,
  input logic [13:0] instr_word,
  input logic [7:0] file_rd_data,
  input logic [7:0] pin_rd_data,
  input logic wake_event,
  output logic [10:0] prog_addr,
  output logic fetch_strobe,
  output logic [6:0] file_addr,
  output logic file_rd_en,
  output logic file_wr_en,
  output logic [7:0] file_wr_data,
  output logic port_read_strobe,
  output logic [7:0] w_reg,
  output logic carry_flag,
  output logic nibble_carry_flag,
  output logic zero_flag,
  output logic timeout_status,
  output logic powerdown_status,
  output logic sleep_active,
  output logic wdt_clear
);

  idec_phase_type phase;
  idec_dec_if dif ();

  logic [13:0] ir, next_ir;
  logic flush, next_flush;
  logic [7:0] operand, next_operand;
  logic taken, next_taken;
  logic jump, next_jump;
  logic [10:0] target, next_target;
  logic [10:0] stack [0:`IDEC_STACK_DEPTH-1];
  logic [2:0] sp, next_sp;
  logic next_push;
  logic [10:0] next_prog_addr;
  logic next_fetch, next_rd, next_wr, next_port_rd, next_wdt_clear;
  logic [6:0] next_file_addr;
  logic [7:0] next_wr_data, next_w;
  logic next_c, next_dc, next_z, next_to, next_pd, next_sleep;

  logic exec, uses_file, is_io, is_sub, wr_file, wr_w, pc_change;
  logic [7:0] src, addend, mask, res;
  logic [8:0] sum;
  logic [4:0] nib;
  logic res_c, upd_c, upd_z, skip;

  idec_phase u_phase (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .phase(phase)
  );

  idec_decode u_decode (
    .dif(dif.decoder)
  );

  assign dif.word = ir;
  // A flushed or sleeping cycle executes nothing; a flushed one still fetches the next word
  assign exec = !flush && !sleep_active;
  assign is_io = (dif.file_addr == `IDEC_IO_PORT_ADDR);

  // ****************************************
  // Operation decode and arithmetic
  // ****************************************
  always_comb begin
    uses_file = (dif.group == GRP_BIT) ||
                ((dif.group == GRP_BYTE) && (dif.op != OP_NOP) && (dif.op != OP_CLRW));
    mask = 8'h01 << dif.bit_sel;
    src = (dif.group == GRP_LIT) ? dif.lit8 : operand;
    is_sub = (dif.op == OP_SUBWF) || (dif.op == OP_SUBLW);
    addend = is_sub ? ~w_reg : w_reg;
    sum = {1'b0, src} + {1'b0, addend} + {8'h00, is_sub};
    nib = {1'b0, src[3:0]} + {1'b0, addend[3:0]} + {4'h0, is_sub};
    res = src;
    res_c = carry_flag;
    upd_c = 1'b0;
    upd_z = 1'b1;
    skip = 1'b0;
    case (dif.op)
      OP_ADDWF, OP_ADDLW, OP_SUBWF, OP_SUBLW: begin
        res = sum[7:0];
        res_c = sum[8];
        upd_c = 1'b1;
      end
      OP_ANDWF, OP_ANDLW: res = src & w_reg;
      OP_IORWF, OP_IORLW: res = src | w_reg;
      OP_XORWF, OP_XORLW: res = src ^ w_reg;
      OP_COMF: res = ~src;
      OP_DECF: res = 8'(src - 8'h01);
      OP_INCF: res = 8'(src + 8'h01);
      OP_CLRW, OP_ZERO_FILE: res = 8'h00;
      OP_MOVWF: begin
        res = w_reg;
        upd_z = 1'b0;
      end
      OP_DECFSZ, OP_INCFSZ: begin
        res = (dif.op == OP_DECFSZ) ? 8'(src - 8'h01) : 8'(src + 8'h01);
        skip = (res == 8'h00);
        upd_z = 1'b0;
      end
      OP_RRF, OP_RLF: begin
        res = (dif.op == OP_RRF) ? {carry_flag, src[7:1]} : {src[6:0], carry_flag};
        res_c = (dif.op == OP_RRF) ? src[0] : src[7];
        upd_c = 1'b1;
        upd_z = 1'b0;
      end
      OP_SWAPF: begin
        res = {src[3:0], src[7:4]};
        upd_z = 1'b0;
      end
      OP_BCF, OP_BSF: begin
        res = (dif.op == OP_BSF) ? (src | mask) : (src & ~mask);
        upd_z = 1'b0;
      end
      OP_BTFSC, OP_BTFSS: begin
        skip = ((src & mask) != 8'h00) == (dif.op == OP_BTFSS);
        upd_z = 1'b0;
      end
      OP_MOVF: res = src;
      default: upd_z = 1'b0;
    endcase
    wr_file = ((dif.group == GRP_BYTE) && dif.dest && (dif.op != OP_NOP)) ||
              (dif.op == OP_BCF) || (dif.op == OP_BSF);
    wr_w = ((dif.group == GRP_BYTE) && !dif.dest && (dif.op != OP_NOP)) ||
           (dif.op == OP_MOVLW) || (dif.op == OP_RETLW) || (dif.op == OP_IORLW) ||
           (dif.op == OP_ANDLW) || (dif.op == OP_XORLW) || (dif.op == OP_SUBLW) ||
           (dif.op == OP_ADDLW);
    pc_change = (dif.op == OP_CALL) || (dif.op == OP_GOTO) || (dif.op == OP_RETURN) ||
                (dif.op == OP_RETFIE) || (dif.op == OP_RETLW);
  end

  // ****************************************
  // Cycle sequencing
  // ****************************************
  always_comb begin
    next_ir = ir;
    next_flush = flush;
    next_operand = operand;
    next_taken = taken;
    next_jump = jump;
    next_target = target;
    next_sp = sp;
    next_push = 1'b0;
    next_prog_addr = prog_addr;
    next_fetch = 1'b0;
    next_rd = 1'b0;
    next_wr = 1'b0;
    next_port_rd = 1'b0;
    next_wdt_clear = 1'b0;
    next_file_addr = file_addr;
    next_wr_data = file_wr_data;
    next_w = w_reg;
    next_c = carry_flag;
    next_dc = nibble_carry_flag;
    next_z = zero_flag;
    next_to = timeout_status;
    next_pd = powerdown_status;
    next_sleep = sleep_active && !wake_event;
    // On wake, ir still holds the standby word; kill the rest of this cycle
    if (sleep_active && wake_event) begin
      next_flush = 1'b1;
    end
    unique case (phase)
      PH_Q1: begin
        next_file_addr = dif.file_addr;
        if (exec && uses_file) begin
          next_rd = 1'b1;
          next_port_rd = is_io;
        end
      end
      PH_Q2: begin
        if (exec && uses_file) begin
          next_operand = is_io ? pin_rd_data : file_rd_data;
        end
      end
      PH_Q3: begin
        next_taken = 1'b0;
        next_jump = 1'b0;
        if (exec) begin
          next_taken = skip || pc_change;
          next_jump = pc_change;
          if (wr_file) begin
            next_wr = 1'b1;
            next_wr_data = res;
          end
          if (wr_w) begin
            next_w = res;
          end
          if (upd_z) begin
            next_z = (res == 8'h00);
          end
          if (upd_c) begin
            next_c = res_c;
          end
          if (is_sub || (dif.op == OP_ADDWF) || (dif.op == OP_ADDLW)) begin
            next_dc = nib[4];
          end
          case (dif.op)
            OP_GOTO: next_target = dif.lit11;
            OP_CALL: begin
              next_target = dif.lit11;
              next_push = 1'b1;
              next_sp = 3'(sp + 3'h1);
            end
            OP_RETURN, OP_RETFIE, OP_RETLW: begin
              next_target = stack[3'(sp - 3'h1)];
              next_sp = 3'(sp - 3'h1);
            end
            OP_SLEEP: begin
              next_pd = 1'b0;
              next_to = 1'b1;
              next_sleep = 1'b1;
            end
            OP_CLRWDT: begin
              next_pd = 1'b1;
              next_to = 1'b1;
              next_wdt_clear = 1'b1;
            end
            default: next_target = target;
          endcase
        end
        next_fetch = !next_sleep;
      end
      PH_Q4: begin
        if (fetch_strobe) begin
          next_ir = instr_word;
          next_prog_addr = jump ? target : 11'(prog_addr + 11'h001);
          next_flush = taken;
        end
      end
      default: next_flush = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ir <= 14'h0000;
      flush <= 1'b1;
      operand <= 8'h00;
      taken <= 1'b0;
      jump <= 1'b0;
      target <= `IDEC_RESET_VECTOR;
      sp <= 3'h0;
      prog_addr <= `IDEC_RESET_VECTOR;
      fetch_strobe <= 1'b0;
      file_rd_en <= 1'b0;
      file_wr_en <= 1'b0;
      port_read_strobe <= 1'b0;
      wdt_clear <= 1'b0;
      file_addr <= 7'h00;
      file_wr_data <= 8'h00;
      w_reg <= `IDEC_RST_W;
      carry_flag <= 1'b0;
      nibble_carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      timeout_status <= `IDEC_RST_TIMEOUT;
      powerdown_status <= `IDEC_RST_POWERDOWN;
      sleep_active <= 1'b0;
    end else begin
      ir <= next_ir;
      flush <= next_flush;
      operand <= next_operand;
      taken <= next_taken;
      jump <= next_jump;
      target <= next_target;
      sp <= next_sp;
      prog_addr <= next_prog_addr;
      fetch_strobe <= next_fetch;
      file_rd_en <= next_rd;
      file_wr_en <= next_wr;
      port_read_strobe <= next_port_rd;
      wdt_clear <= next_wdt_clear;
      file_addr <= next_file_addr;
      file_wr_data <= next_wr_data;
      w_reg <= next_w;
      carry_flag <= next_c;
      nibble_carry_flag <= next_dc;
      zero_flag <= next_z;
      timeout_status <= next_to;
      powerdown_status <= next_pd;
      sleep_active <= next_sleep;
    end
  end

  // ****************************************
  // Return stack
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `IDEC_STACK_DEPTH; i++) begin
        stack[i] <= `IDEC_RESET_VECTOR;
      end
    end else if (next_push) begin
      stack[sp] <= prog_addr;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic exec_q1, exec_q3;
  assign exec_q1 = (phase == PH_Q1) && exec;
  assign exec_q3 = (phase == PH_Q3) && exec;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_q_round;
    (phase == PH_Q2) ##1 (phase == PH_Q3) ##1 (phase == PH_Q4) ##1 (phase == PH_Q1);
  endsequence

  sequence s_quiet_cycle;
    !file_rd_en ##2 (!file_wr_en && $stable(w_reg));
  endsequence

  a_phase_round: assert property ((phase == PH_Q1) |=> s_q_round)
    else $error("instruction cycle is not four clocks");
  a_fetch_spacing: assert property (fetch_strobe |=> !fetch_strobe [*3])
    else $error("fetch strobes closer than one cycle");
  a_group_bit: assert property ((dif.group == GRP_BIT) |->
    (dif.word[13:12] == 2'h1) && (dif.file_addr == dif.word[6:0]))
    else $error("bit group mis-split");
  a_nop_dontcare: assert property ((dif.word[13:7] == 7'h00) && (dif.word[4:0] == 5'h00)
    |-> (dif.op == OP_NOP))
    else $error("no-op depends on don't-care bits");
  a_dest_w: assert property (exec_q3 && (dif.group == GRP_BYTE) && !dif.dest
    |=> !file_wr_en)
    else $error("d=0 wrote the file register");
  a_dest_file: assert property (exec_q3 && (dif.op == OP_ADDWF) && dif.dest
    |=> file_wr_en && (file_addr == $past(dif.file_addr)) && $stable(w_reg))
    else $error("d=1 result not written to the file register");
  a_bit_single: assert property (exec_q3 && (dif.op == OP_BCF)
    |=> file_wr_data == (operand & ~(8'h01 << $past(dif.bit_sel))))
    else $error("bit clear touched other bits");
  a_lit_w: assert property (exec_q3 && (dif.op == OP_MOVLW)
    |=> w_reg == $past(dif.lit8))
    else $error("8-bit literal not loaded");
  a_goto_target: assert property (exec_q3 && (dif.op == OP_GOTO)
    |=> ##1 (prog_addr == $past(dif.lit11, 2)) && flush && (phase == PH_Q1))
    else $error("jump target or flush wrong");
  a_flush_quiet: assert property (((phase == PH_Q1) && flush) |-> ##1 s_quiet_cycle)
    else $error("flushed cycle had a side effect");
  a_read_first: assert property (file_wr_en |-> $past(file_rd_en, 2))
    else $error("file write without prior read");
  a_port_clear: assert property (exec_q1 && (dif.op == OP_ZERO_FILE) && is_io
    |=> port_read_strobe ##2 (file_wr_en && (file_wr_data == 8'h00)))
    else $error("port zeroing skipped its read");
  a_pin_value: assert property ((phase == PH_Q2) && exec && uses_file && is_io
    |=> operand == $past(pin_rd_data))
    else $error("port read used the latch");
  a_standby: assert property (exec_q3 && (dif.word == `IDEC_ENC_SLEEP)
    |=> !powerdown_status && timeout_status && sleep_active && !fetch_strobe)
    else $error("standby status not updated");

endmodule // idec_core

//--- hw/idec_dec_if.sv
// Decoded fields of the instruction word, between the core and its decoder.
// Assumes the core drives the word and the decoder answers combinationally.
`timescale 1ns/1ps

interface idec_dec_if import idec_pkg::*; ();
  logic [13:0] word;
  idec_group_type group;
  idec_op_type op;
  logic [6:0] file_addr;
  logic dest;
  logic [2:0] bit_sel;
  logic [7:0] lit8;
  logic [10:0] lit11;

  modport decoder (input word, output group, op, file_addr, dest, bit_sel, lit8, lit11);
  modport user (output word, input group, op, file_addr, dest, bit_sel, lit8, lit11);
endinterface

//--- hw/idec_decode.sv
// Combinational splitter of a 14-bit instruction word into group, operation, fields.
// Assumes the word is held stable by the core for a whole instruction cycle.
`timescale 1ns/1ps
`include "idec_params.svh"

module idec_decode
  import idec_pkg::*;
(
  idec_dec_if.decoder dif
);

  // ****************************************
  // Field split and classification
  // ****************************************
  always_comb begin
    dif.file_addr = dif.word[6:0];
    dif.dest = dif.word[`IDEC_DEST_BIT];
    dif.bit_sel = dif.word[`IDEC_BSEL_LSB +: 3];
    dif.lit8 = dif.word[7:0];
    dif.lit11 = dif.word[10:0];
    dif.group = GRP_BYTE;
    dif.op = OP_NOP;
    case (dif.word[13:12])
      2'h0: begin
        case (dif.word[11:8])
          4'h0: begin
            if (dif.word[7]) begin
              dif.op = OP_MOVWF;
            end else begin
              // Control codes; the rest of this space is a no-op whatever its x bits
              case (dif.word)
                `IDEC_ENC_RETURN: begin dif.group = GRP_LIT; dif.op = OP_RETURN; end
                `IDEC_ENC_RETFIE: begin dif.group = GRP_LIT; dif.op = OP_RETFIE; end
                `IDEC_ENC_SLEEP: begin dif.group = GRP_LIT; dif.op = OP_SLEEP; end
                `IDEC_ENC_CLRWDT: begin dif.group = GRP_LIT; dif.op = OP_CLRWDT; end
                default: dif.op = OP_NOP;
              endcase
            end
          end
          4'h1: dif.op = dif.word[7] ? OP_ZERO_FILE : OP_CLRW;
          4'h2: dif.op = OP_SUBWF;
          4'h3: dif.op = OP_DECF;
          4'h4: dif.op = OP_IORWF;
          4'h5: dif.op = OP_ANDWF;
          4'h6: dif.op = OP_XORWF;
          4'h7: dif.op = OP_ADDWF;
          4'h8: dif.op = OP_MOVF;
          4'h9: dif.op = OP_COMF;
          4'hA: dif.op = OP_INCF;
          4'hB: dif.op = OP_DECFSZ;
          4'hC: dif.op = OP_RRF;
          4'hD: dif.op = OP_RLF;
          4'hE: dif.op = OP_SWAPF;
          default: dif.op = OP_INCFSZ;
        endcase
      end
      2'h1: begin
        dif.group = GRP_BIT;
        case (dif.word[11:10])
          2'h0: dif.op = OP_BCF;
          2'h1: dif.op = OP_BSF;
          2'h2: dif.op = OP_BTFSC;
          default: dif.op = OP_BTFSS;
        endcase
      end
      2'h2: begin
        dif.group = GRP_LIT;
        dif.op = dif.word[11] ? OP_GOTO : OP_CALL;
      end
      default: begin
        dif.group = GRP_LIT;
        casez (dif.word[11:8])
          4'b00??: dif.op = OP_MOVLW;
          4'b01??: dif.op = OP_RETLW;
          4'b1000: dif.op = OP_IORLW;
          4'b1001: dif.op = OP_ANDLW;
          4'b1010: dif.op = OP_XORLW;
          4'b110?: dif.op = OP_SUBLW;
          4'b111?: dif.op = OP_ADDLW;
          default: dif.op = OP_NOP;
        endcase
      end
    endcase
  end

endmodule // idec_decode

//--- hw/idec_params.svh
// Constants of the instruction decoder: encodings, field positions, reset values.
// Assumes inclusion by every design file that decodes or sequences instructions.

`ifndef IDEC_PARAMS_SVH
`define IDEC_PARAMS_SVH

`define IDEC_WORD_W 14
`define IDEC_Q_PER_CYCLE 4
`define IDEC_FILE_ADDR_MAX 7'h7F
`define IDEC_IO_PORT_ADDR 7'h05
`define IDEC_RESET_VECTOR 11'h000
`define IDEC_STACK_DEPTH 8
`define IDEC_DEST_BIT 7
`define IDEC_BSEL_LSB 7
`define IDEC_ENC_RETURN 14'h0008
`define IDEC_ENC_RETFIE 14'h0009
`define IDEC_ENC_SLEEP 14'h0063
`define IDEC_ENC_CLRWDT 14'h0064
`define IDEC_RST_W 8'h00
`define IDEC_RST_TIMEOUT 1'b1
`define IDEC_RST_POWERDOWN 1'b1

`endif

//--- hw/idec_phase.sv
// Four-phase sequencer that divides the oscillator into instruction cycles.
// Assumes ref_clk is the oscillator and resetn an asynchronous active-low reset.
`timescale 1ns/1ps
`include "idec_params.svh"

module idec_phase
  import idec_pkg::*;
(
  input logic ref_clk,
  input logic resetn,
  output idec_phase_type phase
);

  idec_phase_type next_phase;

  // ****************************************
  // Phase rotation
  // ****************************************
  always_comb begin
    unique case (phase)
      PH_Q1: next_phase = PH_Q2;
      PH_Q2: next_phase = PH_Q3;
      PH_Q3: next_phase = PH_Q4;
      PH_Q4: next_phase = PH_Q1;
      default: next_phase = PH_Q1;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase <= PH_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  a_phase_onehot: assert property (@(posedge ref_clk) disable iff (!resetn)
    $onehot(phase)) else $error("phase code not one-hot");

endmodule // idec_phase

//--- hw/idec_pkg.sv
// Types shared by the instruction decoder modules.
// Assumes nothing beyond a SystemVerilog compiler.

package idec_pkg;

  typedef enum logic [1:0] {
    GRP_BYTE = 2'h0,
    GRP_BIT = 2'h1,
    GRP_LIT = 2'h2
  } idec_group_type;

  typedef enum logic [5:0] {
    OP_NOP, OP_MOVWF, OP_CLRW, OP_ZERO_FILE, OP_SUBWF, OP_DECF, OP_IORWF,
    OP_ANDWF, OP_XORWF, OP_ADDWF, OP_MOVF, OP_COMF, OP_INCF, OP_DECFSZ,
    OP_RRF, OP_RLF, OP_SWAPF, OP_INCFSZ, OP_BCF, OP_BSF, OP_BTFSC, OP_BTFSS,
    OP_CALL, OP_GOTO, OP_MOVLW, OP_RETLW, OP_IORLW, OP_ANDLW, OP_XORLW,
    OP_SUBLW, OP_ADDLW, OP_RETURN, OP_RETFIE, OP_SLEEP, OP_CLRWDT
  } idec_op_type;

  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } idec_phase_type;

endpackage

//--- tb/eight_bit_mcu_instruction_decoder_tb.sv
// Self-checking bench of the decoder core running short programs.
// Assumes the core timing of one fetch per four clocks after a flush cycle.
`timescale 1ns/1ps

module eight_bit_mcu_instruction_decoder_tb;
  import idec_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] pin_rd_data = 8'h00;
  logic wake_event = 1'b0;
  logic [13:0] instr_word;
  logic [7:0] file_rd_data, file_wr_data, w_reg;
  logic [10:0] prog_addr;
  logic [6:0] file_addr;
  logic fetch_strobe, file_rd_en, file_wr_en, port_read_strobe;
  logic carry_flag, nibble_carry_flag, zero_flag;
  logic timeout_status, powerdown_status, sleep_active, wdt_clear;
  int n_errors = 0;
  int checked = 0;
  int n_rd, n_prs, n_wdc;
  logic [1:0] gap;
  logic skip;
  logic [10:0] held;

  idec_core DUT (.ref_clk(ref_clk), .resetn(resetn), .instr_word(instr_word),
    .file_rd_data(file_rd_data), .pin_rd_data(pin_rd_data), .wake_event(wake_event),
    .prog_addr(prog_addr), .fetch_strobe(fetch_strobe), .file_addr(file_addr),
    .file_rd_en(file_rd_en), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
    .port_read_strobe(port_read_strobe), .w_reg(w_reg), .carry_flag(carry_flag),
    .nibble_carry_flag(nibble_carry_flag), .zero_flag(zero_flag),
    .timeout_status(timeout_status), .powerdown_status(powerdown_status),
    .sleep_active(sleep_active), .wdt_clear(wdt_clear));

  idec_mem_model PM (.ref_clk(ref_clk), .prog_addr(prog_addr), .instr_word(instr_word),
    .file_addr(file_addr), .file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
    .file_wr_data(file_wr_data));

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Clears the program, then holds reset for 20 clocks; ends on the release edge
  task automatic do_reset();
    for (int i = 0; i < 2048; i++) PM.rom[i] = 14'h0000;
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Fetch spacing, read and port strobe counts
  always @(posedge ref_clk) begin
    if (!resetn) begin
      gap = 2'h0;
      skip = 1'b0;
      n_rd = 0;
      n_prs = 0;
      n_wdc = 0;
    end else begin
      if (file_rd_en === 1'b1) n_rd++;
      if (port_read_strobe === 1'b1) n_prs++;
      if (wdt_clear === 1'b1) n_wdc++;
      if (sleep_active === 1'b1) skip = 1'b1;
      if (fetch_strobe === 1'b1) begin
        if (!skip) check({12'h000, gap}, 14'h0003);
        gap = 2'h0;
        skip = 1'b0;
      end else begin
        gap = gap + 2'h1;
      end
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic byte_ops();
    do_reset();
    PM.rom[0] = 14'h333C;
    PM.rom[1] = 14'h00A0;
    PM.rom[2] = 14'h0720;
    PM.rom[3] = 14'h07A0;
    step(17);
    check({6'h00, w_reg}, 14'h0078);
    check({6'h00, PM.regs[7'h20]}, 14'h003C);
    step(4);
    check({6'h00, PM.regs[7'h20]}, 14'h00B4);
    check({6'h00, w_reg}, 14'h0078);
    check({11'h000, carry_flag, nibble_carry_flag, zero_flag}, 14'h0002);
    check(14'(n_rd), 14'h0003);
  endtask

  task automatic bit_ops();
    do_reset();
    PM.regs[7'h21] = 8'h05;
    PM.rom[0] = 14'h17A1;
    PM.rom[1] = 14'h1021;
    step(13);
    check({6'h00, PM.regs[7'h21]}, 14'h0084);
    check({6'h00, w_reg}, 14'h0000);
  endtask

  task automatic jump_skip();
    do_reset();
    PM.regs[7'h21] = 8'h84;
    PM.rom[0] = 14'h2810;
    PM.rom[1] = 14'h30FF;
    PM.rom[11'h010] = 14'h1FA1;
    PM.rom[11'h011] = 14'h30EE;
    PM.rom[11'h012] = 14'h3011;
    step(13);
    check({6'h00, w_reg}, 14'h0000);
    check({3'h0, prog_addr}, 14'h0011);
    step(8);
    check({6'h00, w_reg}, 14'h0000);
    check({3'h0, prog_addr}, 14'h0013);
    step(4);
    check({6'h00, w_reg}, 14'h0011);
  endtask

  task automatic port_rmw();
    do_reset();
    PM.regs[7'h05] = 8'hFF;
    pin_rd_data <= 8'h5A;
    PM.rom[0] = 14'h0805;
    PM.rom[1] = 14'h0185;
    step(13);
    check({6'h00, w_reg}, 14'h005A);
    check({6'h00, PM.regs[7'h05]}, 14'h0000);
    check({13'h0000, zero_flag}, 14'h0001);
    check(14'(n_prs), 14'h0002);
    check(14'(n_rd), 14'h0002);
  endtask

  task automatic standby();
    do_reset();
    PM.rom[0] = 14'h0063;
    PM.rom[1] = 14'h3042;
    PM.rom[2] = 14'h0064;
    step(12);
    held = prog_addr;
    check({11'h000, sleep_active, powerdown_status, timeout_status}, 14'h0005);
    step(8);
    check({3'h0, prog_addr}, {3'h0, held});
    check({6'h00, w_reg}, 14'h0000);
    @(posedge ref_clk);
    wake_event <= 1'b1;
    @(posedge ref_clk);
    wake_event <= 1'b0;
    step(12);
    check({6'h00, w_reg}, 14'h0042);
    check({11'h000, sleep_active, powerdown_status, timeout_status}, 14'h0003);
    check(14'(n_wdc), 14'h0001);
  endtask

  // Call, return with literal (don't-care bits set), then store W at the return address
  task automatic call_ret();
    do_reset();
    PM.rom[0] = 14'h2020;
    PM.rom[1] = 14'h00A2;
    PM.rom[11'h020] = 14'h375C;
    step(17);
    check({3'h0, prog_addr}, 14'h0001);
    check({6'h00, w_reg}, 14'h005C);
    step(8);
    check({6'h00, PM.regs[7'h22]}, 14'h005C);
    check({3'h0, prog_addr}, 14'h0003);
  endtask

  initial begin
    byte_ops();
    bit_ops();
    jump_skip();
    port_rmw();
    standby();
    call_ret();
    end_sim();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    end_sim();
  end
endmodule // eight_bit_mcu_instruction_decoder_tb

//--- tb/idec_mem_model.sv
// Program memory and file register array on the far side of the decoder core.
// Assumes the bench fills rom and regs by hierarchical writes between runs.
`timescale 1ns/1ps

module idec_mem_model (
  input wire logic ref_clk,
  input wire logic [10:0] prog_addr,
  output logic [13:0] instr_word,
  input wire logic [6:0] file_addr,
  output logic [7:0] file_rd_data,
  input wire logic file_wr_en,
  input wire logic [7:0] file_wr_data
);
  // ****************************************
  // Storage
  // ****************************************
  logic [13:0] rom [0:2047];
  logic [7:0] regs [0:127];

  // Word is ready long before the fetch edge
  assign instr_word = rom[prog_addr];
  assign file_rd_data = regs[file_addr];

  always @(posedge ref_clk) begin
    if (file_wr_en) begin
      regs[file_addr] <= file_wr_data;
    end
  end
endmodule // idec_mem_model
